// File: source_select_pkg.sv
// shared constants for the drive command source selector
package source_select_pkg;
	// register byte offsets
	localparam logic [7:0] CTRL_OFFSET = 8'h00;
	localparam logic [7:0] AUTO_OFFSET = 8'h04;
	localparam logic [7:0] SERIAL_OFFSET = 8'h08;
	localparam logic [7:0] STATUS_OFFSET = 8'h0C;
	localparam logic [7:0] REF_OFFSET = 8'h10;
	// control and auto register fields
	localparam int RUN_SRC_POS = 0;
	localparam int FREQ_SRC_POS = 4;
	localparam int AUTO_EN_POS = 8;
	localparam int IN8_FUNC_POS = 16;
	localparam int AUTO_RUN_POS = 16;
	// reset values
	localparam logic RUN_SRC_RESET = 1'b0;
	localparam logic [3:0] FREQ_SRC_RESET = 4'h1;
	localparam logic [4:0] IN8_FUNC_RESET = 5'h00;
	// function code of input eight that opens the serial link
	localparam logic [4:0] IN8_FUNC_SERIAL = 5'h0F;
	// run command sources
	localparam logic RUN_SRC_PANEL = 1'b0;
	localparam logic RUN_SRC_TERMINAL = 1'b1;
	// frequency sources
	typedef enum logic [3:0] {
		FSRC_KEYS = 4'h0,
		FSRC_POT = 4'h1,
		FSRC_AIN1 = 4'h2,
		FSRC_AIN2 = 4'h3,
		FSRC_SUM = 4'h4,
		FSRC_MAX = 4'h5,
		FSRC_MIN = 4'h6,
		FSRC_PID = 4'h7,
		FSRC_UPDOWN = 4'h8
	} freq_src_type;
	localparam logic [3:0] FREQ_SRC_LAST = 4'h8;
	// reference step timing while a key or terminal is held
	localparam int CLK_PERIOD_NS = 25;
	localparam int STEP_TIME_NS = 100000;
	localparam int STEP_CYC = STEP_TIME_NS / CLK_PERIOD_NS;
	localparam logic [11:0] STEP_CYC_LAST = 12'(STEP_CYC - 1);
	localparam int PIN_COUNT = 8;
endpackage

// File: pin_sync.sv
// two-flop synchronisers for the terminal and key pins
`timescale 1ns/10ps
module pin_sync import source_select_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [PIN_COUNT-1:0] pin_in,
	output logic [PIN_COUNT-1:0] pin_sync_out
);
	logic [PIN_COUNT-1:0] meta_r;
	logic [PIN_COUNT-1:0] sync_r;
	genvar i;
	generate
		for (i = 0; i < PIN_COUNT; i++) begin : g_bit
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					meta_r[i] <= 1'b0;
					sync_r[i] <= 1'b0;
				end else begin
					meta_r[i] <= pin_in[i];
					sync_r[i] <= meta_r[i];
				end
			end
		end
	endgenerate
	assign pin_sync_out = sync_r;
endmodule

// File: ref_stepper.sv
// up/down reference counter stepped at a fixed rate while held
`timescale 1ns/10ps
module ref_stepper import source_select_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic enable,
	input wire logic up,
	input wire logic down,
	output logic [11:0] value
);
	logic [11:0] value_r;
	logic [11:0] value_nxt;
	logic [11:0] tick_r;
	logic [11:0] tick_nxt;
	always_comb begin
		value_nxt = value_r;
		tick_nxt = 12'h000;
		// up and down together cancel, so the count stays put
		if (enable && (up ^ down)) begin
			if (tick_r == STEP_CYC_LAST) begin
				tick_nxt = 12'h000;
				if (up && value_r != 12'hFFF) begin
					value_nxt = value_r + 12'h001;
				end else if (down && value_r != 12'h000) begin
					value_nxt = value_r - 12'h001;
				end
			end else begin
				tick_nxt = tick_r + 12'h001;
			end
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			value_r <= 12'h000;
			tick_r <= 12'h000;
		end else begin
			value_r <= value_nxt;
			tick_r <= tick_nxt;
		end
	end
	assign value = value_r;
endmodule

// File: source_selector.sv
// run command and frequency reference source selector with APB registers
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// How it works
// RULE1: run source 0 runs on panel forward key or serial link; resets to 0.
// RULE2: run source 1 runs while forward terminal is on, stops when off.
// RULE3: frequency source 0 lets panel keys change reference while running.
// RULE4: frequency source 1 takes reference from the panel potentiometer.
// RULE5: frequency source 2 takes reference from analog input one.
// RULE6: frequency source 3 takes reference from analog input two.
// RULE7: frequency source 4 adds both analog inputs sampled together.
// RULE8: frequency source 5 takes the larger analog input.
// RULE9: frequency source 6 takes the smaller analog input.
// RULE10: frequency source 7 takes reference from the PID loop output.
// RULE11: frequency source 8 steps reference by up/down terminals.
// RULE12: auto operation overrides both source selectors.
// RULE13: serial link enabled only with input eight code 15 and tied low.
// RULE14: keep acceleration and deceleration below 2.0 s when PID used.
// RULE15: out-of-range selector writes are ignored; previous source stays.
module source_selector import source_select_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic forward_key,
	input wire logic stop_key,
	input wire logic panel_key_up,
	input wire logic panel_key_down,
	input wire logic forward_run_input,
	input wire logic updown_up,
	input wire logic updown_down,
	input wire logic multi_input_eight_n,
	input wire logic [11:0] panel_pot,
	input wire logic [11:0] analog_input_one,
	input wire logic [11:0] analog_input_two,
	input wire logic [11:0] pid_output,
	output logic run_forward,
	output logic [12:0] speed_reference,
	output logic link_enable
);
	logic [PIN_COUNT-1:0] pins_s;
	logic fwd_key_s, stop_key_s, fwd_in_s, in8_low_s;
	logic fwd_key_d_r, stop_key_d_r;
	logic fwd_key_d_nxt, stop_key_d_nxt;
	logic [11:0] keys_value, updown_value;
	logic run_src_r, run_src_nxt;
	freq_src_type freq_src_r, freq_src_nxt;
	logic auto_en_r, auto_en_nxt;
	logic [4:0] in8_func_r, in8_func_nxt;
	logic [12:0] auto_ref_r, auto_ref_nxt;
	logic auto_run_r, auto_run_nxt;
	logic serial_run_r, serial_run_nxt;
	logic run_r, run_nxt;
	logic [12:0] ref_r, ref_nxt;
	logic link_r, link_nxt;
	logic pready_r, pready_nxt;
	logic pslverr_r, pslverr_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic wr_en, serial_wr;
	logic [12:0] ain1_x, ain2_x;

	////////////////////////////////////////////////////////////////////////////////
	pin_sync u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.pin_in({multi_input_eight_n, updown_down, updown_up, forward_run_input,
			panel_key_down, panel_key_up, stop_key, forward_key}),
		.pin_sync_out(pins_s)
	);
	assign fwd_key_s = pins_s[0];
	assign stop_key_s = pins_s[1];
	assign fwd_in_s = pins_s[4];
	// reads as tied for two cycles after reset; harmless, the function code resets to 0
	assign in8_low_s = ~pins_s[7];

	// panel keys only move the reference while the drive runs
	ref_stepper u_keys (
		.pclk(pclk),
		.presetn(presetn),
		.enable(run_r && !auto_en_r && freq_src_r == FSRC_KEYS), // see RULE3
		.up(pins_s[2]),
		.down(pins_s[3]),
		.value(keys_value)
	);
	ref_stepper u_updown (
		.pclk(pclk),
		.presetn(presetn),
		.enable(!auto_en_r && freq_src_r == FSRC_UPDOWN), // see RULE11
		.up(pins_s[5]),
		.down(pins_s[6]),
		.value(updown_value)
	);

	////////////////////////////////////////////////////////////////////////////////
	// bus: zero wait states, answer registered in the setup cycle
	assign wr_en = psel && penable && pready_r && pwrite;
	assign serial_wr = wr_en && paddr == SERIAL_OFFSET && link_r;

	always_comb begin
		pready_nxt = psel && !penable;
		pslverr_nxt = 1'b0;
		prdata_nxt = 32'h0000_0000;
		if (psel && !penable) begin
			case (paddr)
				CTRL_OFFSET: prdata_nxt = {11'h000, in8_func_r, 7'h00, auto_en_r,
					freq_src_r, 3'h0, run_src_r};
				AUTO_OFFSET: prdata_nxt = {15'h0000, auto_run_r, 3'h0, auto_ref_r};
				SERIAL_OFFSET: prdata_nxt = {31'h0000_0000, serial_run_r};
				STATUS_OFFSET: prdata_nxt = {29'h0000_0000, auto_en_r, link_r, run_r};
				REF_OFFSET: prdata_nxt = {19'h0_0000, ref_r};
				default: pslverr_nxt = 1'b1;
			endcase
		end
	end

	always_comb begin
		run_src_nxt = run_src_r;
		freq_src_nxt = freq_src_r;
		auto_en_nxt = auto_en_r;
		in8_func_nxt = in8_func_r;
		auto_ref_nxt = auto_ref_r;
		auto_run_nxt = auto_run_r;
		serial_run_nxt = serial_run_r;
		if (wr_en && paddr == CTRL_OFFSET) begin
			run_src_nxt = pwdata[RUN_SRC_POS];
			// an unknown frequency code leaves the current source in charge
			if (pwdata[FREQ_SRC_POS+3:FREQ_SRC_POS] <= FREQ_SRC_LAST) begin // see RULE15
				freq_src_nxt = freq_src_type'(pwdata[FREQ_SRC_POS+3:FREQ_SRC_POS]);
			end
			auto_en_nxt = pwdata[AUTO_EN_POS];
			in8_func_nxt = pwdata[IN8_FUNC_POS+4:IN8_FUNC_POS];
		end
		if (wr_en && paddr == AUTO_OFFSET) begin
			auto_ref_nxt = pwdata[12:0];
			auto_run_nxt = pwdata[AUTO_RUN_POS];
		end
		// serial writes are dropped while the link is closed
		if (serial_wr) begin // see RULE13
			serial_run_nxt = pwdata[0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
			run_src_r <= RUN_SRC_RESET; // see RULE1
			freq_src_r <= freq_src_type'(FREQ_SRC_RESET);
			auto_en_r <= 1'b0;
			in8_func_r <= IN8_FUNC_RESET;
			auto_ref_r <= 13'h0000;
			auto_run_r <= 1'b0;
			serial_run_r <= 1'b0;
		end else begin
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
			prdata_r <= prdata_nxt;
			run_src_r <= run_src_nxt;
			freq_src_r <= freq_src_nxt;
			auto_en_r <= auto_en_nxt;
			in8_func_r <= in8_func_nxt;
			auto_ref_r <= auto_ref_nxt;
			auto_run_r <= auto_run_nxt;
			serial_run_r <= serial_run_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// run command
	always_comb begin
		fwd_key_d_nxt = fwd_key_s;
		stop_key_d_nxt = stop_key_s;
		link_nxt = in8_func_r == IN8_FUNC_SERIAL && in8_low_s; // see RULE13
		run_nxt = run_r;
		if (auto_en_r) begin
			run_nxt = auto_run_r; // see RULE12
		end else if (run_src_r == RUN_SRC_TERMINAL) begin
			run_nxt = fwd_in_s; // see RULE2
		end else begin
			// a stop press beats a simultaneous forward press
			if (stop_key_s && !stop_key_d_r) begin
				run_nxt = 1'b0;
			end else if (fwd_key_s && !fwd_key_d_r) begin
				run_nxt = 1'b1; // see RULE1
			end else if (serial_wr) begin
				run_nxt = pwdata[0]; // see RULE1
			end
		end
	end

	// frequency reference
	assign ain1_x = {1'b0, analog_input_one};
	assign ain2_x = {1'b0, analog_input_two};
	always_comb begin
		ref_nxt = ref_r;
		if (auto_en_r) begin
			ref_nxt = auto_ref_r; // see RULE12
		end else begin
			case (freq_src_r)
				FSRC_KEYS: ref_nxt = {1'b0, keys_value}; // see RULE3
				FSRC_POT: ref_nxt = {1'b0, panel_pot}; // see RULE4
				FSRC_AIN1: ref_nxt = ain1_x; // see RULE5
				FSRC_AIN2: ref_nxt = ain2_x; // see RULE6
				FSRC_SUM: ref_nxt = ain1_x + ain2_x; // see RULE7
				FSRC_MAX: ref_nxt = (ain1_x > ain2_x) ? ain1_x : ain2_x; // see RULE8
				FSRC_MIN: ref_nxt = (ain1_x < ain2_x) ? ain1_x : ain2_x; // see RULE9
				FSRC_PID: ref_nxt = {1'b0, pid_output}; // see RULE10
				FSRC_UPDOWN: ref_nxt = {1'b0, updown_value}; // see RULE11
				default: ref_nxt = ref_r; // see RULE15
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fwd_key_d_r <= 1'b0;
			stop_key_d_r <= 1'b0;
			link_r <= 1'b0;
			run_r <= 1'b0;
			ref_r <= 13'h0000;
		end else begin
			fwd_key_d_r <= fwd_key_d_nxt;
			stop_key_d_r <= stop_key_d_nxt;
			link_r <= link_nxt;
			run_r <= run_nxt;
			ref_r <= ref_nxt;
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign run_forward = run_r;
	assign speed_reference = ref_r;
	assign link_enable = link_r;

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	fwd_key_run_a: assert property ((!auto_en_r && run_src_r == RUN_SRC_PANEL && fwd_key_s && !fwd_key_d_r // see RULE1
		&& !(stop_key_s && !stop_key_d_r)) |=> run_forward)
		else $error("forward key did not start the drive");
	terminal_run_a: assert property ((!auto_en_r && run_src_r == RUN_SRC_TERMINAL) // see RULE2
		|=> run_forward == $past(fwd_in_s))
		else $error("run does not follow the forward terminal");
	keys_hold_a: assert property ((!run_r && !auto_en_r && freq_src_r == FSRC_KEYS) // see RULE3
		##1 (!auto_en_r && freq_src_r == FSRC_KEYS) |=> $stable(speed_reference))
		else $error("panel keys moved the reference while stopped");
	pot_ref_a: assert property ((!auto_en_r && freq_src_r == FSRC_POT) // see RULE4
		|=> speed_reference == {1'b0, $past(panel_pot)})
		else $error("reference does not follow the potentiometer");
	ain1_ref_a: assert property ((!auto_en_r && freq_src_r == FSRC_AIN1) // see RULE5
		|=> speed_reference == {1'b0, $past(analog_input_one)})
		else $error("reference does not follow analog input one");
	ain2_ref_a: assert property ((!auto_en_r && freq_src_r == FSRC_AIN2) // see RULE6
		|=> speed_reference == {1'b0, $past(analog_input_two)})
		else $error("reference does not follow analog input two");
	sum_ref_a: assert property ((!auto_en_r && freq_src_r == FSRC_SUM) // see RULE7
		|=> speed_reference == 13'($past(ain1_x) + $past(ain2_x)))
		else $error("sum reference wrong");
	max_ref_a: assert property ((!auto_en_r && freq_src_r == FSRC_MAX) // see RULE8
		|=> speed_reference >= $past(ain1_x) && speed_reference >= $past(ain2_x))
		else $error("max reference wrong");
	min_ref_a: assert property ((!auto_en_r && freq_src_r == FSRC_MIN) // see RULE9
		|=> speed_reference <= $past(ain1_x) && speed_reference <= $past(ain2_x))
		else $error("min reference wrong");
	pid_ref_a: assert property ((!auto_en_r && freq_src_r == FSRC_PID) // see RULE10
		|=> speed_reference == {1'b0, $past(pid_output)})
		else $error("reference does not follow the PID output");
	updown_ref_a: assert property ((!auto_en_r && freq_src_r == FSRC_UPDOWN) // see RULE11
		|=> speed_reference == {1'b0, $past(updown_value)})
		else $error("reference does not follow the up/down terminals");
	auto_override_a: assert property (auto_en_r |=> speed_reference == $past(auto_ref_r) // see RULE12
		&& run_forward == $past(auto_run_r))
		else $error("auto operation did not take priority");
	link_gate_a: assert property ((in8_func_r != IN8_FUNC_SERIAL || !in8_low_s) |=> !link_enable) // see RULE13
		else $error("serial link opened without its input set up");
	bad_select_a: assert property ((wr_en && paddr == CTRL_OFFSET // see RULE15
		&& pwdata[FREQ_SRC_POS+3:FREQ_SRC_POS] > FREQ_SRC_LAST) |=> $stable(freq_src_r))
		else $error("invalid frequency source was accepted");
	serial_closed_a: assert property ((wr_en && paddr == SERIAL_OFFSET && !link_r) // see RULE13
		|=> $stable(serial_run_r))
		else $error("serial write taken while the link was closed");
	// bus handshake: zero wait states, error only alongside ready
	apb_ready_a: assert property ((psel && !penable) |=> pready)
		else $error("no ready in the access cycle");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("error reported without ready");

	terminal_run_c: cover property (run_src_r == RUN_SRC_TERMINAL && fwd_in_s ##2 run_forward);
	auto_mode_c: cover property (auto_en_r ##1 auto_en_r && run_forward);
	serial_run_c: cover property (serial_wr && pwdata[0] ##1 run_forward);
	bad_write_c: cover property (wr_en && paddr == CTRL_OFFSET && pwdata[7:4] > FREQ_SRC_LAST);
	keys_step_c: cover property (run_r && freq_src_r == FSRC_KEYS ##1 $changed(keys_value));
endmodule

// File: panel_terminal_model.sv
// model of the operator panel keys, control terminals and input eight wiring
`timescale 1ns/10ps
module panel_terminal_model (
	input wire logic [6:0] press,
	input wire logic in8_tied,
	output logic forward_key,
	output logic stop_key,
	output logic panel_key_up,
	output logic panel_key_down,
	output logic forward_run_input,
	output logic updown_up,
	output logic updown_down,
	output logic multi_input_eight_n
);
	// contacts are bare switches: no debounce, the block syncs them itself
	assign forward_key = press[0];
	assign stop_key = press[1];
	assign panel_key_up = press[2];
	assign panel_key_down = press[3];
	assign forward_run_input = press[4];
	assign updown_up = press[5];
	assign updown_down = press[6];
	// reads low only when the user wires input eight to common
	assign multi_input_eight_n = ~in8_tied;
endmodule

// File: source_selector_tb_top.sv
// self-checking bench for the command source selector
`timescale 1ns/10ps
module source_selector_tb_top;
	import source_select_pkg::*;
	logic pclk, presetn, psel, penable, pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic pready, pslverr, e, in8_tied;
	logic [6:0] press;
	logic fk, sk, ku, kd, fri, uu, ud, m8n, run_forward, link_enable;
	logic [11:0] panel_pot, analog_input_one, analog_input_two, pid_output;
	logic [12:0] speed_reference;
	logic [12:0] expv [8];
	int err_total, samples_checked;
	////////////////////////////////////////////////////////////////////////////////
	source_selector source_selector_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.forward_key(fk), .stop_key(sk), .panel_key_up(ku), .panel_key_down(kd), .forward_run_input(fri),
		.updown_up(uu), .updown_down(ud), .multi_input_eight_n(m8n), .panel_pot(panel_pot),
		.analog_input_one(analog_input_one), .analog_input_two(analog_input_two), .pid_output(pid_output),
		.run_forward(run_forward), .speed_reference(speed_reference), .link_enable(link_enable));
	panel_terminal_model panel_terminal_model_inst (.press(press), .in8_tied(in8_tied), .forward_key(fk),
		.stop_key(sk), .panel_key_up(ku), .panel_key_down(kd), .forward_run_input(fri), .updown_up(uu),
		.updown_down(ud), .multi_input_eight_n(m8n));
	always #12.5 pclk = ~pclk;
	////////////////////////////////////////////////////////////////////////////////
	task automatic finish_test();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		samples_checked++;
		if (got !== exp) begin
			$display("CHECK FAILED at %0t: %s got %0h exp %0h", $time, msg, got, exp);
			err_total++;
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// held request until pready is seen at an edge; the bound cuts a hang
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			chk(32'h0, 32'h1, "apb timeout");
			finish_test();
		end else begin
			q = prdata;
			e = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
			@(posedge pclk);
		end
	endtask
	function automatic logic [31:0] ctrl(input logic r, input logic [3:0] f, input logic au, input logic [4:0] fn);
		return (32'(fn) << IN8_FUNC_POS) | (32'(au) << AUTO_EN_POS) | (32'(f) << FREQ_SRC_POS) | 32'(r);
	endfunction
	task automatic hold_step(input int bit_no, input int hi);
		press[bit_no] <= 1'b1;
		cyc(STEP_CYC + 100);
		press[bit_no] <= 1'b0;
		cyc(4);
		chk(32'(speed_reference >= 13'h0001 && speed_reference <= 13'(hi)), 32'h1, "ref step");
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		{psel, penable, pwrite} = 3'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		press = 7'h00;
		in8_tied = 1'b0;
		// sum overflows 12 bits on purpose; inputs one and two differ for max/min
		panel_pot = 12'h456;
		analog_input_one = 12'hC00;
		analog_input_two = 12'h700;
		pid_output = 12'h123;
		expv = '{13'h0, 13'h0456, 13'h0C00, 13'h0700, 13'h1300, 13'h0C00, 13'h0700, 13'h0123};
		err_total = 0;
		samples_checked = 0;
		cyc(16);
		presetn <= 1'b1;
		cyc(2);
		apb(1'b0, CTRL_OFFSET, 32'h0);
		chk(q, ctrl(RUN_SRC_RESET, FREQ_SRC_RESET, 1'b0, IN8_FUNC_RESET), "ctrl reset");
		chk(32'(speed_reference), 32'(expv[1]), "pot ref");
		apb(1'b0, 8'h20, 32'h0);
		chk(32'(e), 32'h1, "unmapped");
		$display("test reset done");
		for (int s = 1; s < 8; s++) begin
			// pid is a fixed word here; ramp times are the user's and stay short while it is chosen
			apb(1'b1, CTRL_OFFSET, ctrl(1'b0, 4'(s), 1'b0, 5'h00));
			cyc(3);
			chk(32'(speed_reference), 32'(expv[s]), "source ref");
		end
		apb(1'b1, CTRL_OFFSET, ctrl(1'b0, 4'h9, 1'b0, 5'h00));
		cyc(3);
		chk(32'(speed_reference), 32'(expv[7]), "bad code kept");
		$display("test sources done");
		apb(1'b1, CTRL_OFFSET, ctrl(RUN_SRC_PANEL, FSRC_KEYS, 1'b0, 5'h00));
		press[0] <= 1'b1;
		cyc(4);
		press[0] <= 1'b0;
		cyc(2);
		chk(32'(run_forward), 32'h1, "key run");
		hold_step(2, 2);
		press[1] <= 1'b1;
		cyc(4);
		press[1] <= 1'b0;
		cyc(2);
		chk(32'(run_forward), 32'h0, "key stop");
		$display("test panel done");
		apb(1'b1, CTRL_OFFSET, ctrl(RUN_SRC_TERMINAL, FSRC_UPDOWN, 1'b0, 5'h00));
		press[4] <= 1'b1;
		cyc(4);
		chk(32'(run_forward), 32'h1, "terminal run");
		hold_step(5, 4);
		press[4] <= 1'b0;
		cyc(4);
		chk(32'(run_forward), 32'h0, "terminal stop");
		$display("test terminal done");
		in8_tied <= 1'b1;
		apb(1'b1, CTRL_OFFSET, ctrl(RUN_SRC_PANEL, FSRC_POT, 1'b0, IN8_FUNC_SERIAL));
		cyc(4);
		chk(32'(link_enable), 32'h1, "link open");
		apb(1'b1, SERIAL_OFFSET, 32'h1);
		cyc(2);
		chk(32'(run_forward), 32'h1, "serial run");
		apb(1'b1, SERIAL_OFFSET, 32'h0);
		cyc(2);
		chk(32'(run_forward), 32'h0, "serial stop");
		in8_tied <= 1'b0;
		cyc(4);
		chk(32'(link_enable), 32'h0, "link closed");
		apb(1'b1, SERIAL_OFFSET, 32'h1);
		cyc(2);
		chk(32'(run_forward), 32'h0, "serial refused");
		$display("test serial done");
		apb(1'b1, AUTO_OFFSET, 32'h0001_0ABC);
		apb(1'b1, CTRL_OFFSET, ctrl(RUN_SRC_TERMINAL, FSRC_AIN1, 1'b1, 5'h00));
		cyc(3);
		chk(32'(speed_reference), 32'h0000_0ABC, "auto ref");
		chk(32'(run_forward), 32'h1, "auto run");
		apb(1'b0, STATUS_OFFSET, 32'h0);
		chk(q & 32'h4, 32'h4, "auto status");
		apb(1'b0, REF_OFFSET, 32'h0);
		chk(q, 32'h0000_0ABC, "ref readback");
		$display("test auto done");
		finish_test();
	end
endmodule
